// ---- fsg_pkg.sv ----
// Package holding constants for the flash security access guard
package fsg_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  PSC_ADDR     = 8'h8f;
   localparam logic [7:0]  ACL_ADDR     = 8'hb7;
   localparam logic [7:0]  PSC_RESET    = 8'h00;
   localparam logic [7:0]  ACL_RESET    = 8'h00;
   localparam int          PSC_WE_BIT   = 0;
   localparam int          PSC_EE_BIT   = 1;
   // ****************************************
   // Flash layout
   // ****************************************
   localparam logic [15:0] WE_LOCK_ADDR = 16'h7dfe;
   localparam logic [15:0] RD_LOCK_ADDR = 16'h7dff;
   localparam logic [15:0] LOCK_PAGE_LO = 16'h7c00;
   localparam logic [15:0] LOCK_PAGE_HI = 16'h7dff;
   localparam int          BLOCK_SHIFT  = 12;
   localparam int          SECTOR_SHIFT = 9;
   localparam logic [7:0]  BLOCKED_DATA = 8'h00;
   localparam logic [7:0]  LOW_BYTE     = 8'h00;
   localparam logic [7:0]  LOCK_ERASED  = 8'hff;
   // ****************************************
   // Operation kinds
   // ****************************************
   typedef enum logic [1:0] {FSG_OP_READ, FSG_OP_WRITE, FSG_OP_ERASE} fsg_op_t;
   typedef enum logic [1:0] {FSG_ER_NONE, FSG_ER_SECTOR, FSG_ER_PAGE, FSG_ER_ALL} fsg_erase_t;
endpackage

// ---- fsg_lock_if.sv ----
// Interface carrying the lock byte pair between top and lock store
`timescale 1ns/1ps
interface fsg_lock_if;
   logic       load;
   logic [7:0] load_rd;
   logic [7:0] load_we;
   logic       clr;
   logic       wr_sel_rd;
   logic [7:0] wr_data;
   logic       erase;
   logic [7:0] rd_lock;
   logic [7:0] we_lock;
   modport ctrl  (output load, load_rd, load_we, clr, wr_sel_rd, wr_data, erase, input rd_lock, we_lock);
   modport store (input load, load_rd, load_we, clr, wr_sel_rd, wr_data, erase, output rd_lock, we_lock);
endinterface

// ---- fsg_lock_store.sv ----
// Shadow store of the two lock bytes, clear-only except on erase or load
`timescale 1ns/1ps
module fsg_lock_store (
   input  wire logic   i_core_clk,
   input  wire logic   i_resetn,
   fsg_lock_if.store   lk
);
   logic [7:0] rd_r;
   logic [7:0] we_r;
   logic [7:0] rd_nxt;
   logic [7:0] we_nxt;

   // ****************************************
   // Next value
   // ****************************************
   // Writes can only clear bits; only erase or load returns them to 1
   assign rd_nxt = lk.erase ? fsg_pkg::LOCK_ERASED : lk.load ? lk.load_rd :
                   (lk.clr &&  lk.wr_sel_rd) ? (rd_r & lk.wr_data) : rd_r;
   assign we_nxt = lk.erase ? fsg_pkg::LOCK_ERASED : lk.load ? lk.load_we :
                   (lk.clr && !lk.wr_sel_rd) ? (we_r & lk.wr_data) : we_r;

   // Reset leaves everything locked until the flash copy is loaded
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_r <= 8'h00;
         we_r <= 8'h00;
      end else begin
         rd_r <= rd_nxt;
         we_r <= we_nxt;
      end
   end

   assign lk.rd_lock = rd_r;
   assign lk.we_lock = we_r;
endmodule

// ---- fsg_guard.sv ----
// Flash security access guard: write/erase enables, debug locks, read limit
// Operation
// - Locks come from bytes 0x7DFE and 0x7DFF
// - Each lock bit covers one 4 kbyte block
// - Read lock bit 0 refuses debug reads
// - Write lock bit 0 refuses debug writes, erases
// - Lock sector: software writes yes, erase no
// - Lock bits always readable and clearable
// - Only debug full or lock-page erase sets locks again
// - Debug erase of lock byte erases everything
// - Other lock-page debug erase erases that page
// - Read limit is access limit byte then 0x00
// - Upper code barred from lower flash accesses
// - Barred reads return 0x00
// - Instruction fetch from lower stays allowed
// - Lower code has unrestricted access
// - Limit 0x00 leaves all flash readable
// - Registers reset to zero, unused bits zero
// - Both enables: write erases the sector
`timescale 1ns/1ps
module fsg_guard #(
   parameter int ADDR_W = 16
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_resetn,
   // Special function register port
   input  wire logic              i_sfr_wr,
   input  wire logic              i_sfr_rd,
   input  wire logic [7:0]        i_sfr_addr,
   input  wire logic [7:0]        i_sfr_wdata,
   output logic      [7:0]        o_sfr_rdata,
   // Lock bytes from flash after power-up
   input  wire logic              i_lock_load,
   input  wire logic [7:0]        i_lock_rd_byte,
   input  wire logic [7:0]        i_lock_we_byte,
   // Processor request
   input  wire logic              i_cpu_req,
   input  wire logic              i_cpu_fetch,
   input  wire logic              i_cpu_code_rd,
   input  wire logic              i_cpu_data_wr,
   input  wire logic [ADDR_W-1:0] i_cpu_pc,
   input  wire logic [ADDR_W-1:0] i_cpu_addr,
   input  wire logic [7:0]        i_cpu_wdata,
   // Debug port request
   input  wire logic              i_dbg_req,
   input  wire fsg_pkg::fsg_op_t  i_dbg_op,
   input  wire logic [ADDR_W-1:0] i_dbg_addr,
   input  wire logic [7:0]        i_dbg_wdata,
   // Flash read data
   input  wire logic [7:0]        i_flash_rdata,
   // Decision outputs
   output logic                   o_done,
   output logic                   o_grant,
   output logic                   o_refused,
   output fsg_pkg::fsg_op_t       o_flash_op,
   output fsg_pkg::fsg_erase_t    o_erase_kind,
   output logic [ADDR_W-1:0]      o_flash_addr,
   output logic [7:0]             o_flash_wdata,
   output logic                   o_rdata_mask,
   output logic [7:0]             o_rdata,
   output logic [7:0]             o_rd_lock,
   output logic [7:0]             o_we_lock
);
   // ****************************************
   // Registers
   // ****************************************
   logic [1:0]  psc_r;
   logic [7:0]  acl_r;
   logic        acl_done_r;
   logic [7:0]  sfr_rdata_r;

   fsg_lock_if lk ();
   fsg_lock_store u_locks (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .lk         (lk.store)
   );

   // ****************************************
   // Register port decode
   // ****************************************
   wire psc_hit = (i_sfr_addr == fsg_pkg::PSC_ADDR);
   wire acl_hit = (i_sfr_addr == fsg_pkg::ACL_ADDR);
   wire psc_we  = i_sfr_wr && psc_hit;
   wire acl_we  = i_sfr_wr && acl_hit && !acl_done_r;
   wire [7:0] psc_view = {6'h00, psc_r};
   wire [7:0] sfr_mux = psc_hit ? psc_view : acl_hit ? acl_r : 8'h00;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         psc_r       <= fsg_pkg::PSC_RESET[1:0];
         acl_r       <= fsg_pkg::ACL_RESET;
         acl_done_r  <= 1'b0;
         sfr_rdata_r <= 8'h00;
      end else begin
         if (psc_we) begin
            psc_r <= {i_sfr_wdata[fsg_pkg::PSC_EE_BIT], i_sfr_wdata[fsg_pkg::PSC_WE_BIT]};
         end
         if (acl_we) begin
            acl_r      <= i_sfr_wdata;
            acl_done_r <= 1'b1;
         end
         if (i_sfr_rd) begin
            sfr_rdata_r <= sfr_mux;
         end
      end
   end

   wire store_we = psc_r[fsg_pkg::PSC_WE_BIT];
   wire store_ee = psc_r[fsg_pkg::PSC_EE_BIT];

   // ****************************************
   // Software read limit
   // ****************************************
   // Zero limit means every address is at or above it, so nothing is lower
   wire [15:0] read_limit = {acl_r, fsg_pkg::LOW_BYTE};
   wire [15:0] pc16       = 16'(i_cpu_pc);
   wire [15:0] ad16       = 16'(i_cpu_addr);
   wire        pc_upper   = (pc16 >= read_limit);
   wire        ad_lower   = (ad16 < read_limit);
   wire        sw_barred  = pc_upper && ad_lower;

   // ****************************************
   // Processor decision
   // ****************************************
   wire ad_lock_sector = (ad16[15:fsg_pkg::SECTOR_SHIFT] ==
                          fsg_pkg::WE_LOCK_ADDR[15:fsg_pkg::SECTOR_SHIFT]);
   wire cpu_is_erase = i_cpu_data_wr && store_we && store_ee;
   wire cpu_is_write = i_cpu_data_wr && store_we && !store_ee;
   wire cpu_wr_ok    = store_we && !sw_barred && !(store_ee && ad_lock_sector);
   // Fetches never consult the limit
   wire cpu_rd_ok    = i_cpu_fetch || !sw_barred;
   wire cpu_ok       = i_cpu_data_wr ? cpu_wr_ok : cpu_rd_ok;
   wire cpu_is_read  = !i_cpu_data_wr;
   wire cpu_lock_wr  = cpu_is_write && cpu_wr_ok &&
                       ((ad16 == fsg_pkg::RD_LOCK_ADDR) || (ad16 == fsg_pkg::WE_LOCK_ADDR));

   // ****************************************
   // Debug port decision
   // ****************************************
   wire [15:0] dbg16    = 16'(i_dbg_addr);
   wire [2:0]  dbg_blk  = dbg16[fsg_pkg::BLOCK_SHIFT +: 3];
   wire        dbg_lockb = (dbg16 == fsg_pkg::RD_LOCK_ADDR) || (dbg16 == fsg_pkg::WE_LOCK_ADDR);
   wire        dbg_page = (dbg16 >= fsg_pkg::LOCK_PAGE_LO) && (dbg16 <= fsg_pkg::LOCK_PAGE_HI);
   wire        rd_open  = lk.rd_lock[dbg_blk];
   wire        we_open  = lk.we_lock[dbg_blk];
   wire        dbg_rd   = (i_dbg_op == fsg_pkg::FSG_OP_READ);
   wire        dbg_wr   = (i_dbg_op == fsg_pkg::FSG_OP_WRITE);
   wire        dbg_er   = (i_dbg_op == fsg_pkg::FSG_OP_ERASE);
   // Lock bytes stay readable and clearable even in a locked block
   wire        dbg_ok   = dbg_rd ? (rd_open || dbg_lockb) :
                          dbg_wr ? (we_open || dbg_lockb) :
                          (dbg_lockb || we_open);
   wire        dbg_full = dbg_er && dbg_lockb;
   wire        dbg_pg   = dbg_er && dbg_page && !dbg_lockb;
   wire        dbg_lock_wr = dbg_wr && dbg_lockb;

   fsg_pkg::fsg_erase_t dbg_kind;
   assign dbg_kind = dbg_full ? fsg_pkg::FSG_ER_ALL :
                     dbg_pg ? fsg_pkg::FSG_ER_PAGE :
                     dbg_er ? fsg_pkg::FSG_ER_SECTOR : fsg_pkg::FSG_ER_NONE;

   // Debug side wins a simultaneous request; the processor request is dropped then
   wire use_dbg = i_dbg_req;
   wire take    = i_dbg_req || i_cpu_req;
   wire ok      = use_dbg ? dbg_ok : cpu_ok;

   fsg_pkg::fsg_op_t cpu_op;
   assign cpu_op = cpu_is_erase ? fsg_pkg::FSG_OP_ERASE :
                   i_cpu_data_wr ? fsg_pkg::FSG_OP_WRITE : fsg_pkg::FSG_OP_READ;

   // ****************************************
   // Lock store control
   // ****************************************
   assign lk.load      = i_lock_load;
   assign lk.load_rd   = i_lock_rd_byte;
   assign lk.load_we   = i_lock_we_byte;
   assign lk.clr       = use_dbg ? (dbg_lock_wr && i_dbg_req) : (i_cpu_req && cpu_lock_wr);
   assign lk.wr_sel_rd = use_dbg ? (dbg16 == fsg_pkg::RD_LOCK_ADDR) : (ad16 == fsg_pkg::RD_LOCK_ADDR);
   assign lk.wr_data   = use_dbg ? i_dbg_wdata : i_cpu_wdata;
   // Both whole and lock-page erases wipe the lock bytes
   assign lk.erase     = i_dbg_req && dbg_ok && (dbg_full || dbg_pg);

   // ****************************************
   // Output registers
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_done        <= 1'b0;
         o_grant       <= 1'b0;
         o_refused     <= 1'b0;
         o_flash_op    <= fsg_pkg::FSG_OP_READ;
         o_erase_kind  <= fsg_pkg::FSG_ER_NONE;
         o_flash_addr  <= '0;
         o_flash_wdata <= 8'h00;
         o_rdata_mask  <= 1'b0;
      end else begin
         o_done    <= take;
         o_grant   <= take && ok;
         o_refused <= take && !ok;
         if (take) begin
            o_flash_op    <= use_dbg ? i_dbg_op : cpu_op;
            o_erase_kind  <= use_dbg ? dbg_kind : (cpu_is_erase ? fsg_pkg::FSG_ER_SECTOR : fsg_pkg::FSG_ER_NONE);
            o_flash_addr  <= use_dbg ? i_dbg_addr : i_cpu_addr;
            o_flash_wdata <= use_dbg ? i_dbg_wdata : i_cpu_wdata;
            o_rdata_mask  <= use_dbg ? (dbg_rd && !dbg_ok) : (cpu_is_read && !cpu_rd_ok);
         end
      end
   end

   // Read data one cycle after the grant; masked reads give zero
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= o_rdata_mask ? fsg_pkg::BLOCKED_DATA : i_flash_rdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rd_lock <= 8'h00;
         o_we_lock <= 8'h00;
      end else begin
         o_rd_lock <= lk.rd_lock;
         o_we_lock <= lk.we_lock;
      end
   end

   assign o_sfr_rdata = sfr_rdata_r;
endmodule

// ---- fsg_guard_chk.sv ----
// Port checker of the flash security access guard
`timescale 1ns/1ps
module fsg_guard_chk #(
   parameter int ADDR_W = 16
) (
   input  wire logic                i_core_clk,
   input  wire logic                i_resetn,
   input  wire logic                i_sfr_wr,
   input  wire logic [7:0]          i_sfr_addr,
   input  wire logic [7:0]          i_sfr_wdata,
   input  wire logic                i_lock_load,
   input  wire logic                i_cpu_req,
   input  wire logic                i_cpu_fetch,
   input  wire logic                i_cpu_data_wr,
   input  wire logic [ADDR_W-1:0]   i_cpu_pc,
   input  wire logic [ADDR_W-1:0]   i_cpu_addr,
   input  wire logic                i_dbg_req,
   input  wire fsg_pkg::fsg_op_t    i_dbg_op,
   input  wire logic [ADDR_W-1:0]   i_dbg_addr,
   input  wire logic                o_done,
   input  wire logic                o_grant,
   input  wire logic                o_refused,
   input  wire fsg_pkg::fsg_erase_t o_erase_kind,
   input  wire logic                o_rdata_mask,
   input  wire logic [7:0]          o_rdata,
   input  wire logic [7:0]          o_rd_lock,
   input  wire logic [7:0]          o_we_lock
);
   // ****************************************
   // Write-once mirror of the access limit
   // ****************************************
   logic [7:0] acl_r;
   logic       acl_set_r;
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         acl_r     <= 8'h00;
         acl_set_r <= 1'b0;
      end else if (i_sfr_wr && i_sfr_addr == fsg_pkg::ACL_ADDR && !acl_set_r) begin
         acl_r     <= i_sfr_wdata;
         acl_set_r <= 1'b1;
      end
   end
   wire logic [15:0] lim = {acl_r, fsg_pkg::LOW_BYTE};
   // Debug wins a tie, so a simultaneous processor request is ignored
   wire logic        cpu = i_cpu_req && !i_dbg_req;
   wire logic        dbg_er = i_dbg_req && i_dbg_op == fsg_pkg::FSG_OP_ERASE;
   wire logic        lock_byte = i_dbg_addr[15:1] == 15'h3eff;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_wipe;
      o_rd_lock == fsg_pkg::LOCK_ERASED && o_we_lock == fsg_pkg::LOCK_ERASED;
   endsequence
   sequence s_kind(fsg_pkg::fsg_erase_t k);
      o_grant && o_erase_kind == k;
   endsequence
   AST_UPPER_BLOCKED: assert property (cpu && !i_cpu_fetch && i_cpu_pc >= lim && i_cpu_addr < lim |=> o_refused)
      else $error("upper code reached lower flash");
   AST_MASK_ZERO: assert property (o_done && o_rdata_mask |=> o_rdata == fsg_pkg::BLOCKED_DATA)
      else $error("masked read returned data");
   AST_FETCH_OK: assert property (cpu && i_cpu_fetch && !i_cpu_data_wr |=> o_grant)
      else $error("fetch refused");
   AST_LOWER_FREE: assert property (cpu && !i_cpu_data_wr && i_cpu_pc < lim |=> o_grant && !o_rdata_mask)
      else $error("lower code read refused");
   // Lock outputs trail the store by a cycle, so only a settled lock byte is trusted
   AST_RD_LOCK: assert property (i_dbg_req && i_dbg_op == fsg_pkg::FSG_OP_READ && !lock_byte
      && !o_rd_lock[i_dbg_addr[14:12]] ##1 $stable(o_rd_lock) |-> o_refused)
      else $error("locked debug read granted");
   AST_WE_LOCK: assert property (i_dbg_req && i_dbg_op != fsg_pkg::FSG_OP_READ && !lock_byte
      && !o_we_lock[i_dbg_addr[14:12]] ##1 $stable(o_we_lock) |-> o_refused)
      else $error("locked debug change granted");
   AST_FULL_ERASE: assert property (dbg_er && lock_byte |=> s_kind(fsg_pkg::FSG_ER_ALL) ##1 s_wipe)
      else $error("lock byte erase not full");
   AST_PAGE_ERASE: assert property (dbg_er && i_dbg_addr[15:9] == 7'h3e && !lock_byte && o_we_lock[7]
      ##1 $stable(o_we_lock) |-> s_kind(fsg_pkg::FSG_ER_PAGE) ##1 s_wipe)
      else $error("lock page erase wrong");
   AST_NO_LOCK_SECT: assert property (cpu && i_cpu_addr[15:9] == 7'h3e |=> !(o_grant && o_erase_kind != fsg_pkg::FSG_ER_NONE))
      else $error("lock sector erased by software");
   AST_LOCK_SET: assert property (|({o_rd_lock, o_we_lock} & ~$past({o_rd_lock, o_we_lock}))
      |-> $past(o_grant && o_erase_kind[1]) || $past(i_lock_load, 2))
      else $error("lock bit set without erase");
endmodule
bind fsg_guard fsg_guard_chk #(.ADDR_W(ADDR_W)) u_fsg_guard_chk (.*);

// ---- fsg_flash_model.sv ----
// Flash array stand-in feeding read data to the guard
`timescale 1ns/1ps
module fsg_flash_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_grant,
   input  wire logic [15:0] i_addr,
   output logic      [7:0]  o_rdata
);
   logic [7:0] idle_r = 8'h00;
   // Data is only valid while granted; a toggling pattern exposes stale use
   always @(posedge i_core_clk) begin
      idle_r <= ~idle_r;
   end
   assign o_rdata = i_grant ? (i_addr[7:0] ^ 8'h3c) : idle_r;
endmodule

// ---- tb_fsg_guard.sv ----
// Self-checking bench of the flash security access guard
`timescale 1ns/1ps
module tb_fsg_guard;
   logic                i_core_clk = 1'b0;
   logic                i_resetn, i_sfr_wr, i_sfr_rd, i_lock_load, i_cpu_req, i_cpu_fetch;
   logic                i_cpu_code_rd, i_cpu_data_wr, i_dbg_req, o_done, o_grant, o_refused, o_rdata_mask;
   logic [7:0]          i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_lock_rd_byte, i_lock_we_byte, i_cpu_wdata;
   logic [7:0]          i_dbg_wdata, i_flash_rdata, o_flash_wdata, o_rdata, o_rd_lock, o_we_lock;
   logic [15:0]         i_cpu_pc, i_cpu_addr, i_dbg_addr, o_flash_addr;
   fsg_pkg::fsg_op_t    i_dbg_op, o_flash_op;
   fsg_pkg::fsg_erase_t o_erase_kind;
   int                  n_fail = 0;
   int                  check_count = 0;
   always #20 i_core_clk = ~i_core_clk;
   fsg_guard u_fsg_guard (.*);
   fsg_flash_model u_fsg_flash_model (.i_core_clk(i_core_clk), .i_grant(o_grant), .i_addr(o_flash_addr),
      .o_rdata(i_flash_rdata));
   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
      @(negedge i_core_clk);
      i_sfr_wr = 1'b0;
   endtask
   task automatic sr(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_core_clk);
      {i_sfr_rd, i_sfr_addr} = {1'b1, a};
      @(negedge i_core_clk);
      i_sfr_rd = 1'b0;
      chk(o_sfr_rdata, exp);
   endtask
   // Processor or debug op: 0 read, 1 write, 2 debug erase, 3 fetch; returns when read data has landed
   task automatic go(input logic dbg, input logic [1:0] op, input logic [15:0] pc, a, input logic [7:0] d,
      input logic eg);
      @(negedge i_core_clk);
      {i_dbg_req, i_cpu_req} = {dbg, !dbg};
      i_dbg_op = fsg_pkg::fsg_op_t'(op);
      {i_cpu_fetch, i_cpu_data_wr, i_cpu_code_rd} = {op == 2'd3, op == 2'd1, op == 2'd0};
      {i_cpu_pc, i_cpu_addr, i_dbg_addr, i_cpu_wdata, i_dbg_wdata} = {pc, a, a, d, d};
      @(negedge i_core_clk);
      {i_dbg_req, i_cpu_req} = 2'b00;
      chk({o_done, o_grant, o_refused}, {1'b1, eg, !eg});
      @(negedge i_core_clk);
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {i_resetn, i_sfr_wr, i_sfr_rd, i_lock_load, i_cpu_req, i_dbg_req} = '0;
      {i_cpu_fetch, i_cpu_code_rd, i_cpu_data_wr, i_cpu_pc, i_cpu_addr, i_dbg_addr} = '0;
      {i_sfr_addr, i_sfr_wdata, i_lock_rd_byte, i_lock_we_byte, i_cpu_wdata, i_dbg_wdata} = '0;
      i_dbg_op = fsg_pkg::FSG_OP_READ;
      repeat (20) @(negedge i_core_clk);
      i_resetn = 1'b1;
      sr(fsg_pkg::PSC_ADDR, 8'h00);
      sr(fsg_pkg::ACL_ADDR, 8'h00);
      sr(8'h90, 8'h00);
      go(0, 0, 16'hf000, 16'h0000, 0, 1);
      chk(o_rdata, 8'h3c);
      @(negedge i_core_clk);
      {i_lock_load, i_lock_rd_byte, i_lock_we_byte} = {1'b1, 8'h7f, 8'hfe};
      @(negedge i_core_clk);
      i_lock_load = 1'b0;
      repeat (2) @(negedge i_core_clk);
      chk({o_rd_lock, o_we_lock}, 16'h7ffe);
      for (int b = 0; b < 8; b++) begin
         go(1, 0, 0, {1'b0, b[2:0], 12'h123}, 0, b != 7);
         go(1, 1, 0, {1'b0, b[2:0], 12'h123}, 0, b != 0);
      end
      go(1, 0, 0, 16'h7dff, 0, 1);
      chk(o_rdata_mask, 1'b0);
      go(0, 1, 0, 16'h2000, 8'h55, 0);
      sw(fsg_pkg::PSC_ADDR, 8'hff);
      sr(fsg_pkg::PSC_ADDR, 8'h03);
      go(0, 1, 0, 16'h2000, 8'h55, 1);
      chk({o_flash_op, o_erase_kind}, {fsg_pkg::FSG_OP_ERASE, fsg_pkg::FSG_ER_SECTOR});
      go(0, 1, 0, 16'h7c10, 8'h55, 0);
      sw(fsg_pkg::PSC_ADDR, 8'h01);
      go(0, 1, 0, 16'h2000, 8'h55, 1);
      chk({o_erase_kind, o_flash_wdata}, {fsg_pkg::FSG_ER_NONE, 8'h55});
      chk({o_flash_op, o_flash_addr}, {fsg_pkg::FSG_OP_WRITE, 16'h2000});
      go(0, 1, 0, 16'h7dff, 8'h00, 1);
      go(0, 1, 0, 16'h7dfe, 8'h7c, 1);
      go(0, 1, 0, 16'h7dff, 8'hff, 1);
      chk({o_rd_lock, o_we_lock}, 16'h007c);
      go(1, 2, 0, 16'h7c40, 0, 0);
      go(1, 2, 0, 16'h7dfe, 0, 1);
      chk({o_erase_kind, o_rd_lock, o_we_lock}, {fsg_pkg::FSG_ER_ALL, 16'hffff});
      go(0, 1, 0, 16'h7dff, 8'h00, 1);
      go(1, 2, 0, 16'h7c40, 0, 1);
      chk({o_erase_kind, o_rd_lock}, {fsg_pkg::FSG_ER_PAGE, 8'hff});
      sw(fsg_pkg::ACL_ADDR, 8'h40);
      sw(fsg_pkg::ACL_ADDR, 8'h10);
      sr(fsg_pkg::ACL_ADDR, 8'h40);
      go(0, 0, 16'h5000, 16'h3fff, 0, 0);
      chk({o_rdata_mask, o_rdata}, 9'h100);
      go(0, 0, 16'h5000, 16'h4000, 0, 1);
      chk(o_rdata, 8'h3c);
      go(0, 1, 16'h4000, 16'h3e00, 8'h11, 0);
      go(0, 3, 16'h5000, 16'h1000, 0, 1);
      go(0, 0, 16'h3fff, 16'h6000, 0, 1);
      go(0, 0, 16'h3fff, 16'h0100, 0, 1);
      // Mid-run reset must re-arm the write-once access limit
      @(negedge i_core_clk);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_core_clk);
      i_resetn = 1'b1;
      sr(fsg_pkg::PSC_ADDR, 8'h00);
      sr(fsg_pkg::ACL_ADDR, 8'h00);
      sw(fsg_pkg::ACL_ADDR, 8'h20);
      sr(fsg_pkg::ACL_ADDR, 8'h20);
      conclude();
   end
   // Whole sequence needs well under 400 cycles
   initial begin
      #50000;
      n_fail++;
      conclude();
   end
endmodule
